/* hw/mode_config_defines.vh */
// constants for the module configuration register and reset-time mode sampling
`ifndef MODE_CONFIG_DEFINES_VH
`define MODE_CONFIG_DEFINES_VH
// byte offsets on the register bus
`define OFF_MODULE_CONFIGURATION 4'h0
`define OFF_RESET_STRAPS         4'h4
`define OFF_PIN_FUNCTIONS        4'h8
// field positions in module_configuration
`define BIT_EXT_CLOCK_OFF        15
`define BIT_FREEZE_WATCHDOG      14
`define BIT_FREEZE_BUS_MONITOR   13
`define BIT_DEV_SUPPORT_DISABLE  12
`define BIT_SHOW_HI              9
`define BIT_SHOW_LO              8
`define BIT_SUPERVISOR           7
`define BIT_MODULE_MAP           6
`define BIT_LOW_ADDR_DISABLE     5
`define BIT_RW_DISABLE           4
`define BIT_IRQ_ARB_HI           3
`define BIT_IRQ_ARB_LO           0
// reset values
`define RST_IRQ_ARB              4'hf
`define RST_SHOW                 2'h0
// show cycle modes
`define SHOW_OFF_ARB_ON          2'h0
`define SHOW_ON_ARB_OFF          2'h1
`define SHOW_ON_ARB_ON           2'h2
`define SHOW_ON_ARB_HALT         2'h3
// strap data bit positions
`define STRAP_WIDTH_SEL          1
`define STRAP_BUS_REQ            2
`define STRAP_ADDR19             3
`define STRAP_CS_LO              4
`define STRAP_CS_HI              6
`define STRAP_ADDR23             7
`define STRAP_PORT_E             8
`define STRAP_PORT_F             9
`define STRAP_EMULATION          10
`define STRAP_RESERVED           11
`define STRAP_ROM_EMULATION      13
`define STRAP_NVM_STOP           15
// module base addresses (upper 12 address bits)
`define MAP_LOW_BASE             12'h7ff
`define MAP_HIGH_BASE            12'hfff
// bus responses
`define RESP_OKAY                2'h0
`define RESP_SLVERR              2'h2
`endif

/* hw/system_mode_reset_config.v */
// module configuration register, reset-time mode sampling and pin function decode
`include "mode_config_defines.vh"

// How it works
// - watchdog stops during freeze only when its freeze bit is set
// - bus monitor disabled during freeze only when its freeze bit is set
// - pipe status pins driven unless disabled; disabled pins float except on breakpoint
// - show cycle field selects show cycles, arbitration, and grant-halts-internal modes
// - map bit picks module base 7ff000 or fff000, sets top address bit
// - map bit writes once after reset; cleared map makes module access fail
// - low address disable floats address pins 2..0, mode reset, one write
// - rw strobe disable floats strobe, mode-dependent reset, one write only
// - arbitration priority four bits, resets to f, drives interrupt arbitration
// - during reset, pins from data 15..0, basics from error, clock, breakpoint
// - error pin low gives single chip; data1 low 16-bit, high 8-bit
// - 8-bit mode: low data pins port h; single chip: ports a,b,g,h
// - data pins pulled high, so low at reset selects alternate functions
// - 16-bit mode uses address 18..3 and data 15..0, no ports
// - expanded: data8 low turns bus handshake pins into port e bits
// - emulator select replaces grant acknowledge when error high and data10, data1 low
// - rom emulation select replaces grant when error high and data13, data10, data1 low
// - data15 low at reset stops the erasable nvm array
// - data6..4 at reset set three chip-select pin assignment fields
module system_mode_reset_config
(
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // reset-time strap pins
    input  wire [15:0] data_strap,
    input  wire        bus_error_input,
    input  wire        clock_source_select,
    input  wire        breakpoint_input,
    // system status
    input  wire        freeze,
    input  wire        breakpoint_event,
    input  wire [11:0] module_access_base,
    // freeze and debug controls
    output reg         watchdog_run,
    output reg         bus_monitor_run,
    output reg         pipe_status_oe,
    output reg         ext_clock_off,
    // show cycles and arbitration
    output reg         show_cycles_on,
    output reg         ext_arbitration_on,
    output reg         grant_halts_internal,
    output reg         peripheral_enable_ok,
    output reg  [3:0]  irq_arbitration_priority,
    // address map and bus pins
    output reg         module_addr_top,
    output reg         module_access_fail,
    output reg         low_address_oe,
    output reg         rw_strobe_oe,
    // operating mode
    output reg         mode_single_chip,
    output reg         mode_expanded_16,
    output reg         mode_expanded_8,
    output reg         synth_clock_select,
    output reg         background_mode,
    // pin functions
    output reg         addr_bus_on,
    output reg  [1:0]  data_bus_bytes_on,
    output reg  [3:0]  ports_abgh_on,
    output reg         port_e_select,
    output reg         port_f_select,
    output reg         bus_request_select,
    output reg         func_code_select,
    output reg         addr19_select,
    output reg         addr23_select,
    output reg         emulator_select,
    output reg         rom_emulation_select,
    output reg         block_erase_nvm_stop,
    output reg         reserved_config,
    output reg  [2:0]  pin_assign_second
);

    // ==========
    // strap capture
    // ==========
    // straps are latched every cycle while reset is held, and frozen at release
    reg  [15:0] strap_r;
    reg         err_r;
    reg         mclk_r;
    reg         brk_r;
    reg         in_reset_r;

    always @(posedge aclk)
    begin
        in_reset_r <= ~aresetn;
        if (!aresetn)
        begin
            strap_r <= data_strap;
            err_r   <= bus_error_input;
            mclk_r  <= clock_source_select;
            brk_r   <= breakpoint_input;
        end
    end

    wire single_w   = ~err_r;
    wire exp16_w    = err_r & ~strap_r[`STRAP_WIDTH_SEL];
    wire exp8_w     = err_r &  strap_r[`STRAP_WIDTH_SEL];

    // ==========
    // module configuration register
    // ==========
    reg         ext_off_r;
    reg         frz_wd_r;
    reg         frz_bm_r;
    reg         dev_dis_r;
    reg  [1:0]  show_r;
    reg         supv_r;
    reg         map_r;
    reg         adis_r;
    reg         rwdis_r;
    reg  [3:0]  prio_r;
    reg         map_wr_r;
    reg         adis_wr_r;
    reg         rwdis_wr_r;

    // bus handshake state
    reg         aw_got_r;
    reg         w_got_r;
    reg  [3:0]  aw_addr_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg  [31:0] rdata_nxt;
    reg         rmapped_nxt;

    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_got_r & w_got_r & ~s_axi_bvalid;
    wire cfg_hit  = (aw_addr_r == `OFF_MODULE_CONFIGURATION);
    wire lo_wr    = do_write & cfg_hit & w_strb_r[0];
    wire hi_wr    = do_write & cfg_hit & w_strb_r[1];

    // mode-dependent reset values load from the strap on the first edge after reset release
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_off_r <= 1'b0;
            frz_wd_r  <= 1'b0;
            frz_bm_r  <= 1'b0;
            show_r    <= `RST_SHOW;
            supv_r    <= 1'b1;
            map_r     <= 1'b1;
            prio_r    <= `RST_IRQ_ARB;
            map_wr_r  <= 1'b0;
            adis_wr_r <= 1'b0;
            rwdis_wr_r <= 1'b0;
            dev_dis_r <= 1'b0;
            adis_r    <= 1'b0;
            rwdis_r   <= 1'b0;
        end
        else
        begin
            if (in_reset_r)
            begin
                dev_dis_r <= single_w;
                adis_r    <= single_w;
                rwdis_r   <= single_w;
            end
            if (hi_wr)
            begin
                ext_off_r <= w_data_r[`BIT_EXT_CLOCK_OFF];
                frz_wd_r  <= w_data_r[`BIT_FREEZE_WATCHDOG];
                frz_bm_r  <= w_data_r[`BIT_FREEZE_BUS_MONITOR];
                dev_dis_r <= w_data_r[`BIT_DEV_SUPPORT_DISABLE];
                show_r    <= w_data_r[`BIT_SHOW_HI:`BIT_SHOW_LO];
            end
            if (lo_wr)
            begin
                supv_r <= w_data_r[`BIT_SUPERVISOR];
                prio_r <= w_data_r[`BIT_IRQ_ARB_HI:`BIT_IRQ_ARB_LO];
                // each protected bit takes one write only, then locks
                if (!map_wr_r)
                begin
                    map_r    <= w_data_r[`BIT_MODULE_MAP];
                    map_wr_r <= 1'b1;
                end
                if (!adis_wr_r)
                begin
                    adis_r    <= w_data_r[`BIT_LOW_ADDR_DISABLE];
                    adis_wr_r <= 1'b1;
                end
                if (!rwdis_wr_r)
                begin
                    rwdis_r    <= w_data_r[`BIT_RW_DISABLE];
                    rwdis_wr_r <= 1'b1;
                end
            end
        end
    end

    // ==========
    // axi4-lite slave
    // ==========
    always @*
    begin
        rdata_nxt   = 32'h0;
        rmapped_nxt = 1'b1;
        case (s_axi_araddr)
            `OFF_MODULE_CONFIGURATION:
                rdata_nxt = {16'h0, ext_off_r, frz_wd_r, frz_bm_r, dev_dis_r, 2'h0, show_r,
                             supv_r, map_r, adis_r, rwdis_r, prio_r};
            `OFF_RESET_STRAPS:
                rdata_nxt = {13'h0, brk_r, mclk_r, err_r, strap_r};
            `OFF_PIN_FUNCTIONS:
                rdata_nxt = {29'h0, mode_expanded_8, mode_expanded_16, mode_single_chip};
            default:
                rmapped_nxt = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            aw_addr_r     <= 4'h0;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_got_r      <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take)
            begin
                w_got_r      <= 1'b1;
                w_data_r     <= s_axi_wdata;
                w_strb_r     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_r == `OFF_MODULE_CONFIGURATION) ? `RESP_OKAY : `RESP_SLVERR;
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rdata_nxt;
                s_axi_rresp   <= rmapped_nxt ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ==========
    // control outputs
    // ==========
    wire top_bit_w = map_r;
    wire [11:0] base_w = top_bit_w ? `MAP_HIGH_BASE : `MAP_LOW_BASE;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            watchdog_run         <= 1'b1;
            bus_monitor_run      <= 1'b1;
            pipe_status_oe       <= 1'b0;
            ext_clock_off        <= 1'b0;
            show_cycles_on       <= 1'b0;
            ext_arbitration_on   <= 1'b1;
            grant_halts_internal <= 1'b0;
            peripheral_enable_ok <= 1'b1;
            irq_arbitration_priority <= `RST_IRQ_ARB;
            module_addr_top      <= 1'b1;
            module_access_fail   <= 1'b0;
            low_address_oe       <= 1'b0;
            rw_strobe_oe         <= 1'b0;
        end
        else
        begin
            watchdog_run    <= ~(frz_wd_r & freeze);
            bus_monitor_run <= ~(frz_bm_r & freeze);
            pipe_status_oe  <= ~dev_dis_r | breakpoint_event;
            ext_clock_off   <= ext_off_r;
            show_cycles_on  <= (show_r != `SHOW_OFF_ARB_ON);
            ext_arbitration_on   <= (show_r != `SHOW_ON_ARB_OFF);
            grant_halts_internal <= (show_r == `SHOW_ON_ARB_HALT);
            peripheral_enable_ok <= (show_r == `SHOW_OFF_ARB_ON);
            irq_arbitration_priority <= prio_r;
            module_addr_top    <= top_bit_w;
            // upper lines follow address bit 19, so a cleared map never matches
            module_access_fail <= ~map_r | (module_access_base != base_w);
            low_address_oe     <= ~adis_r & ~single_w;
            rw_strobe_oe       <= ~rwdis_r & ~single_w;
        end
    end

    // ==========
    // mode and pin function decode
    // ==========
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_single_chip     <= 1'b0;
            mode_expanded_16     <= 1'b0;
            mode_expanded_8      <= 1'b0;
            synth_clock_select   <= 1'b1;
            background_mode      <= 1'b0;
            addr_bus_on          <= 1'b0;
            data_bus_bytes_on    <= 2'h0;
            ports_abgh_on        <= 4'h0;
            port_e_select        <= 1'b0;
            port_f_select        <= 1'b0;
            bus_request_select   <= 1'b0;
            func_code_select     <= 1'b0;
            addr19_select        <= 1'b0;
            addr23_select        <= 1'b0;
            emulator_select      <= 1'b0;
            rom_emulation_select <= 1'b0;
            block_erase_nvm_stop <= 1'b0;
            reserved_config      <= 1'b0;
            pin_assign_second    <= 3'h7;
        end
        else
        begin
            mode_single_chip   <= single_w;
            mode_expanded_16   <= exp16_w;
            mode_expanded_8    <= exp8_w;
            synth_clock_select <= mclk_r;
            background_mode    <= ~brk_r;
            addr_bus_on        <= err_r;
            data_bus_bytes_on  <= {err_r, exp16_w};
            ports_abgh_on      <= {single_w, single_w, single_w, ~exp16_w};
            port_e_select      <= single_w | ~strap_r[`STRAP_PORT_E];
            port_f_select      <= single_w | (exp16_w & ~strap_r[`STRAP_PORT_F]);
            bus_request_select <= exp16_w & ~strap_r[`STRAP_BUS_REQ];
            func_code_select   <= exp16_w & ~strap_r[`STRAP_BUS_REQ];
            addr19_select      <= exp16_w & ~strap_r[`STRAP_ADDR19];
            addr23_select      <= exp16_w & ~strap_r[`STRAP_ADDR23];
            emulator_select    <= exp16_w & ~strap_r[`STRAP_EMULATION];
            rom_emulation_select <= exp16_w & ~strap_r[`STRAP_EMULATION]
                                  & ~strap_r[`STRAP_ROM_EMULATION];
            block_erase_nvm_stop <= ~strap_r[`STRAP_NVM_STOP];
            reserved_config    <= ~strap_r[`STRAP_RESERVED];
            pin_assign_second  <= strap_r[`STRAP_CS_HI:`STRAP_CS_LO];
        end
    end

endmodule

/* bench/strap_board.sv */
// board strap model, driving the mode pins in reset
module strap_board
(
    // clock and reset
    input  wire         aclk,
    input  wire         aresetn,
    // wanted strap levels
    input  wire  [15:0] want_data,
    input  wire         want_err,
    input  wire         want_clk,
    input  wire         want_brk,
    // strap pins
    output logic [15:0] data_strap          = 16'hffff,
    output logic        bus_error_input     = 1'b0,
    output logic        clock_source_select = 1'b0,
    output logic        breakpoint_input    = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // drive during reset, release afterwards
    // unpulled pins invert once released, so late sampling shows
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            data_strap <= want_data | 16'h0800;
            {bus_error_input, clock_source_select, breakpoint_input} <= {want_err, want_clk, want_brk};
        end
        else
        begin
            data_strap <= 16'hffff;
            {bus_error_input, clock_source_select, breakpoint_input} <= ~{want_err, want_clk, want_brk};
        end
    end
endmodule

/* bench/mode_config_sva.sv */
// assertions on the ports of the configuration block
module mode_config_sva
(
    // clock and reset
    input wire        aclk,
    input wire        aresetn,
    // status inputs
    input wire        freeze,
    input wire        breakpoint_event,
    input wire [11:0] module_access_base,
    // observed outputs
    input wire        watchdog_run,
    input wire        bus_monitor_run,
    input wire        pipe_status_oe,
    input wire        show_cycles_on,
    input wire        ext_arbitration_on,
    input wire        grant_halts_internal,
    input wire        peripheral_enable_ok,
    input wire [3:0]  irq_arbitration_priority,
    input wire        module_addr_top,
    input wire        module_access_fail,
    input wire        low_address_oe,
    input wire        rw_strobe_oe,
    input wire        mode_single_chip,
    input wire        mode_expanded_16,
    input wire        mode_expanded_8,
    input wire [3:0]  ports_abgh_on,
    input wire        emulator_select,
    input wire        rom_emulation_select
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========
    // properties
    // decode outputs settle one edge after release
    sequence s_settled;
        $past(aresetn) ##0 aresetn;
    endsequence
    property p_watchdog_run; !freeze |=> watchdog_run; endproperty
    a_watchdog_run: assert property (p_watchdog_run) else $error("watchdog stopped");
    property p_monitor_run; !freeze |=> bus_monitor_run; endproperty
    a_monitor_run: assert property (p_monitor_run) else $error("monitor stopped");
    property p_pipe_on_break; breakpoint_event |=> pipe_status_oe; endproperty
    a_pipe_on_break: assert property (p_pipe_on_break) else $error("pipe pins float");
    property p_show_modes;
        (show_cycles_on || ext_arbitration_on) && (!grant_halts_internal || show_cycles_on && ext_arbitration_on);
    endproperty
    a_show_modes: assert property (p_show_modes) else $error("bad show mode");
    property p_periph_off; peripheral_enable_ok == !show_cycles_on; endproperty
    a_periph_off: assert property (p_periph_off) else $error("peripherals on in show");
    property p_map_high;
        module_addr_top && $stable(module_addr_top) && $past(module_access_base) == 12'hfff |-> !module_access_fail;
    endproperty
    a_map_high: assert property (p_map_high) else $error("high map fails");
    property p_map_low; !module_addr_top |-> module_access_fail; endproperty
    a_map_low: assert property (p_map_low) else $error("low map passes");
    property p_arb_reset; $rose(aresetn) |-> irq_arbitration_priority == 4'hf; endproperty
    a_arb_reset: assert property (p_arb_reset) else $error("priority not f");
    property p_mode_onehot; s_settled |-> $onehot({mode_single_chip, mode_expanded_16, mode_expanded_8}); endproperty
    a_mode_onehot: assert property (p_mode_onehot) else $error("mode not onehot");
    property p_single_pins;
        mode_single_chip |-> ports_abgh_on == 4'hf && !low_address_oe && !rw_strobe_oe;
    endproperty
    a_single_pins: assert property (p_single_pins) else $error("single chip pins");
    property p_bus16; mode_expanded_16 |-> ports_abgh_on == 4'h0; endproperty
    a_bus16: assert property (p_bus16) else $error("ports in 16-bit");
    property p_rom_emu; rom_emulation_select |-> emulator_select && mode_expanded_16; endproperty
    a_rom_emu: assert property (p_rom_emu) else $error("rom emulation alone");
endmodule

bind system_mode_reset_config mode_config_sva sva_u (.*);

/* bench/system_mode_reset_config_test.sv */
// bench for the configuration block
module system_mode_reset_config_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        aclk = 1'b0, aresetn = 1'b0, freeze = 1'b0, breakpoint_event = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, data_bus_bytes_on;
    logic [15:0] data_strap, want_data = 16'hffff;
    logic        bus_error_input, clock_source_select, breakpoint_input;
    logic        want_err = 1'b1, want_clk = 1'b1, want_brk = 1'b1;
    logic [11:0] module_access_base = 12'h0;
    logic        watchdog_run, bus_monitor_run, pipe_status_oe, ext_clock_off, show_cycles_on;
    logic        ext_arbitration_on, grant_halts_internal, peripheral_enable_ok, module_addr_top;
    logic [3:0]  irq_arbitration_priority, ports_abgh_on;
    logic        module_access_fail, low_address_oe, rw_strobe_oe, mode_single_chip, mode_expanded_16;
    logic        mode_expanded_8, synth_clock_select, background_mode, addr_bus_on, port_e_select;
    logic        port_f_select, bus_request_select, func_code_select, addr19_select, addr23_select;
    logic        emulator_select, rom_emulation_select, block_erase_nvm_stop, reserved_config;
    logic [2:0]  pin_assign_second;
    int          n_errors = 0, checks = 0;

    system_mode_reset_config dut_u (.*);
    strap_board board_u (.*);

    initial
    begin
        forever #50 aclk = ~aclk;
    end
    // ==========
    // expectations
    function automatic logic [26:0] pins_exp(input logic [15:0] d, input logic b, c, k);
        logic e16;
        e16 = b & ~d[1];
        return {~b, e16, b & d[1], ~b | ~d[8], ~b | (e16 & ~d[9]), e16 & ~d[2], e16 & ~d[2], e16 & ~d[3],
                e16 & ~d[7], e16 & ~d[10], e16 & ~d[10] & ~d[13], ~d[15], ~d[11], d[6:4], c, ~k,
                b, b, e16, ~b, ~b, ~b, ~e16, b, b};
    endfunction
    function automatic logic [11:0] ctl_exp(input logic [15:0] v, input logic f, k);
        return {~(v[14] & f), ~(v[13] & f), ~v[12] | k, v[15], v[9:8] != 2'h0, v[9:8] != 2'h1,
                v[9:8] == 2'h3, v[9:8] == 2'h0, v[3:0]};
    endfunction
    // ==========
    // checking and bus tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
            n_errors++;
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic hang(input int n);
        if (n >= 40)
        begin
            chk("handshake", 32'h0, 32'h1);
            close_out();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        s_axi_bready <= 1'b0;
        hang(n);
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er, input string nm);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        s_axi_rready <= 1'b0;
        hang(n);
        chk(nm, s_axi_rdata, ed);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task automatic do_reset(input logic b, input logic [15:0] d);
        @(posedge aclk);
        aresetn <= 1'b0;
        want_err <= b;
        want_data <= d;
        want_clk <= 1'($urandom());
        want_brk <= 1'($urandom());
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask
    // ==========
    // main sequence
    initial
    begin
        logic [15:0] d, v1, v2;
        int m, i;
        void'($urandom(50));
        // m: 0 single, 1 8-bit, 2 16-bit, 3 16-bit emulation
        for (m = 0; m < 4; m++)
        begin
            d = 16'($urandom()) | 16'h0800;
            d[1] = (m == 1);
            if (m == 3)
                d = d & 16'hdbff;
            do_reset(m != 0, d);
            chk("pins", {
                mode_single_chip, mode_expanded_16, mode_expanded_8, port_e_select, port_f_select, bus_request_select,
                func_code_select, addr19_select, addr23_select, emulator_select, rom_emulation_select,
                block_erase_nvm_stop, reserved_config, pin_assign_second, synth_clock_select, background_mode,
                addr_bus_on, data_bus_bytes_on, ports_abgh_on, low_address_oe, rw_strobe_oe},
                pins_exp(d, m != 0, want_clk, want_brk));
            rd(4'h0, {16'h0, 3'h0, !m, 6'h3, {2{!m}}, 4'hf}, 2'h0, "config reset");
            rd(4'h4, {13'h0, want_brk, want_clk, m != 0, d}, 2'h0, "straps");
            rd(4'h8, {29'h0, m == 1, m >= 2, m == 0}, 2'h0, "mode");
            module_access_base <= 12'hfff;
            repeat (2) @(posedge aclk);
            chk("high map", {module_addr_top, module_access_fail}, 2'b10);
            $display("mode test %0d done", m);
        end
        v1 = 16'($urandom()) & 16'hf3bf | 16'h00b0;
        wr(4'h0, {16'h0, v1}, 2'h0);
        rd(4'h0, {16'h0, v1}, 2'h0, "first write");
        chk("locked pins", {module_addr_top, module_access_fail,
            low_address_oe, rw_strobe_oe}, 4'b0100);
        v2 = 16'($urandom()) & 16'hf38f | 16'h00c0;
        wr(4'h0, {16'h0, v2}, 2'h0);
        rd(4'h0, {16'h0, v2[15:7], v1[6:4], v2[3:0]}, 2'h0, "second write");
        $display("write once test done");
        for (i = 0; i < 8; i++)
        begin
            v2 = 16'($urandom()) & 16'hfc8f | 16'h0080 | {6'h0, i[1:0], 8'h0};
            wr(4'h0, {16'h0, v2}, 2'h0);
            freeze <= i[2];
            breakpoint_event <= 1'($urandom());
            repeat (2) @(posedge aclk);
            chk("controls", {
                watchdog_run, bus_monitor_run, pipe_status_oe, ext_clock_off, show_cycles_on, ext_arbitration_on,
                grant_halts_internal, peripheral_enable_ok, irq_arbitration_priority},
                ctl_exp(v2, freeze, breakpoint_event));
        end
        $display("control test done");
        wr(4'hc, 32'h0000ffff, 2'h2);
        wr(4'h4, 32'h0000ffff, 2'h2);
        rd(4'hc, 32'h0, 2'h2, "unmapped read");
        rd(4'h0, {16'h0, v2[15:7], v1[6:4], v2[3:0]}, 2'h0, "after refusal");
        $display("refusal test done");
        do_reset(1'b0, 16'hffff);
        rd(4'h0, 32'h000010f0 | 32'h3f, 2'h0, "config after reset");
        $display("reset again test done");
        close_out();
    end
endmodule
